// *** ext_bus_pkg.sv ***
// Overview of operation
// - Select 1 goes to static controller when bit is 0, SDRAM when 1.
// - Select 3 bit set also enables NAND glue logic on that select.
// - Select 4 bit set keeps it static and enables card slot 1 logic.
// - Select 5 bit set keeps it static and enables card slot 2 logic.
// - Pull-up bit 0 enables pull-ups on data lines 0 to 15; 1 disables.
// - Two-bit drive field picks 1.8 V or 3.3 V, low or high drive.
// - Assignment register is read/write at 0x11c, reset 0x00010000.
// - Bus gives 16 or 32 data bits, 26 address bits, eight selects.
// - Shared pins carry signals of the controller doing the access.
// - Dedicated output carries SDRAM address bit 10; static side unused.
package ext_bus_pkg;
    localparam logic [11:0] CS_ASSIGN_ADDR   = 12'h11c;
    localparam logic [31:0] CS_ASSIGN_RESET  = 32'h00010000;
    localparam int          CS1_SDRAM_BIT    = 1;
    localparam int          CS3_NAND_BIT     = 3;
    localparam int          CS4_CARD1_BIT    = 4;
    localparam int          CS5_CARD2_BIT    = 5;
    localparam int          PULLUP_DIS_BIT   = 8;
    localparam int          DRIVE_LSB        = 16;
    localparam logic [31:0] CS_ASSIGN_MASK   = 32'h0003013a;
    localparam int          ADDR_W           = 26;
    localparam int          DATA_W           = 32;
    localparam int          NCS              = 8;

    typedef enum logic [1:0] {
        DRIVE_18_LOW,
        DRIVE_33_LOW,
        DRIVE_18_HIGH,
        DRIVE_33_HIGH
    } pad_drive_t;
endpackage

// *** ext_bus_pin_mux.sv ***
`timescale 1ns/10ps
module ext_bus_pin_mux
    import ext_bus_pkg::*;
(
    input  wire logic              sdram_owns,
    input  wire logic [ADDR_W-1:0] smc_addr,
    input  wire logic [12:0]       sdr_addr,
    input  wire logic [3:0]        smc_wr_n,
    input  wire logic [3:0]        sdr_dqm_n,
    input  wire logic [DATA_W-1:0] smc_dout,
    input  wire logic [DATA_W-1:0] sdr_dout,
    input  wire logic              smc_doe_n,
    input  wire logic              sdr_doe_n,
    output logic      [ADDR_W-1:0] addr,
    output logic      [3:0]        wr_n,
    output logic      [DATA_W-1:0] dout,
    output logic                   doe_n
);
    // Shared pins follow whichever controller owns the bus
    always_comb begin
        addr  = smc_addr;
        wr_n  = smc_wr_n;
        dout  = smc_dout;
        doe_n = smc_doe_n;
        if (sdram_owns) begin
            addr          = '0;
            addr[11:2]    = sdr_addr[9:0];
            addr[14:13]   = sdr_addr[12:11];
            wr_n          = sdr_dqm_n;
            dout          = sdr_dout;
            doe_n         = sdr_doe_n;
        end
    end
endmodule

// *** ext_bus_cs_mux.sv ***
// Register access over APB was decided locally.
`timescale 1ns/10ps
module ext_bus_cs_mux
    import ext_bus_pkg::*;
(
    input  wire logic                           CLK_SYS,
    input  wire logic                           RST,
    input  wire logic                           PSEL,
    input  wire logic                           PENABLE,
    input  wire logic                           PWRITE,
    input  wire logic [11:0]                    PADDR,
    input  wire logic [31:0]                    PWDATA,
    output logic      [31:0]                    PRDATA,
    output logic                                PREADY,
    output logic                                PSLVERR,
    input  wire logic                           SDRAM_ACCESS,
    input  wire logic [ext_bus_pkg::NCS-1:0]    SMC_CS_N,
    input  wire logic                           SMC_RD_N,
    input  wire logic                           SMC_WE_N,
    input  wire logic [3:0]                     SMC_WR_N,
    input  wire logic [ext_bus_pkg::ADDR_W-1:0] SMC_ADDR,
    input  wire logic [ext_bus_pkg::DATA_W-1:0] SMC_DOUT,
    input  wire logic                           SMC_DOE_N,
    output logic      [ext_bus_pkg::DATA_W-1:0] SMC_DIN,
    output logic                                SMC_WAIT_N,
    input  wire logic                           SDR_CS_N,
    input  wire logic                           SDR_RAS_N,
    input  wire logic                           SDR_CAS_N,
    input  wire logic                           SDR_WE_N,
    input  wire logic [12:0]                    SDR_ADDR,
    input  wire logic [3:0]                     SDR_DQM_N,
    input  wire logic [ext_bus_pkg::DATA_W-1:0] SDR_DOUT,
    input  wire logic                           SDR_DOE_N,
    output logic      [ext_bus_pkg::DATA_W-1:0] SDR_DIN,
    input  wire logic                           WIDE_BUS,
    output logic      [ext_bus_pkg::ADDR_W-1:0] EXT_ADDR,
    output logic      [ext_bus_pkg::NCS-1:0]    EXT_CS_N,
    output logic                                EXT_RD_N,
    output logic                                EXT_WE_N,
    output logic      [3:0]                     EXT_WR_N,
    output logic                                SDRAM_ADDR10_OUT,
    output logic                                EXT_RAS_N,
    output logic                                EXT_CAS_N,
    output logic                                EXT_SDWE_N,
    output logic      [ext_bus_pkg::DATA_W-1:0] EXT_DATA_OUT,
    output logic      [ext_bus_pkg::DATA_W-1:0] EXT_DATA_OE_N,
    input  wire logic [ext_bus_pkg::DATA_W-1:0] EXT_DATA_IN,
    input  wire logic                           EXT_WAIT_N,
    output logic                                NAND_CS_N,
    output logic                                NAND_OE_N,
    output logic                                NAND_WE_N,
    output logic      [1:0]                     CARD_CS_N,
    output logic                                CARD_OE_N,
    output logic                                CARD_WE_N,
    output logic                                DATA_PULLUP_EN,
    output logic      [1:0]                     PAD_DRIVE_CLASS
);
    import ext_bus_pkg::*;

    logic [31:0]       ext_bus_cs_assign;
    logic              cs1_sdram_select;
    logic              cs3_nand_logic_enable;
    logic              cs4_card_slot1_enable;
    logic              cs5_card_slot2_enable;
    logic              sdram_owns;
    logic              wr_access;
    logic              hit;
    logic [ADDR_W-1:0] mux_addr;
    logic [3:0]        mux_wr_n;
    logic [DATA_W-1:0] mux_dout;
    logic              mux_doe_n;
    logic [NCS-1:0]    smc_cs_gated;

    // APB slave: zero wait states, unmapped addresses read zero, no error
    assign hit       = (PADDR == CS_ASSIGN_ADDR);
    assign wr_access = PSEL & PENABLE & PWRITE;
    assign PREADY    = 1'b1;
    assign PSLVERR   = 1'b0;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ext_bus_cs_assign <= CS_ASSIGN_RESET;
        end else if (wr_access && hit) begin
            ext_bus_cs_assign <= PWDATA & CS_ASSIGN_MASK;
        end
    end

    always_comb begin
        PRDATA = 32'h00000000;
        if (PSEL && !PWRITE && hit) begin
            PRDATA = ext_bus_cs_assign;
        end
    end

    assign cs1_sdram_select      = ext_bus_cs_assign[CS1_SDRAM_BIT];
    assign cs3_nand_logic_enable = ext_bus_cs_assign[CS3_NAND_BIT];
    assign cs4_card_slot1_enable = ext_bus_cs_assign[CS4_CARD1_BIT];
    assign cs5_card_slot2_enable = ext_bus_cs_assign[CS5_CARD2_BIT];

    assign DATA_PULLUP_EN  = ~ext_bus_cs_assign[PULLUP_DIS_BIT];
    assign PAD_DRIVE_CLASS = ext_bus_cs_assign[DRIVE_LSB+1:DRIVE_LSB];

    // SDRAM only owns the pins when select 1 is assigned to it
    assign sdram_owns = cs1_sdram_select & SDRAM_ACCESS;

    ext_bus_pin_mux u_pin_mux (
        .sdram_owns (sdram_owns),
        .smc_addr   (SMC_ADDR),
        .sdr_addr   (SDR_ADDR),
        .smc_wr_n   (SMC_WR_N),
        .sdr_dqm_n  (SDR_DQM_N),
        .smc_dout   (SMC_DOUT),
        .sdr_dout   (SDR_DOUT),
        .smc_doe_n  (SMC_DOE_N),
        .sdr_doe_n  (SDR_DOE_N),
        .addr       (mux_addr),
        .wr_n       (mux_wr_n),
        .dout       (mux_dout),
        .doe_n      (mux_doe_n)
    );

    always_comb begin
        smc_cs_gated = SMC_CS_N;
        if (sdram_owns) begin
            smc_cs_gated = {NCS{1'b1}};
        end
        if (cs1_sdram_select) begin
            smc_cs_gated[1] = 1'b1;
        end
    end

    // Registered pin drive
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            EXT_ADDR         <= '0;
            EXT_CS_N         <= {NCS{1'b1}};
            EXT_RD_N         <= 1'b1;
            EXT_WE_N         <= 1'b1;
            EXT_WR_N         <= 4'hf;
            SDRAM_ADDR10_OUT <= 1'b0;
            EXT_RAS_N        <= 1'b1;
            EXT_CAS_N        <= 1'b1;
            EXT_SDWE_N       <= 1'b1;
            EXT_DATA_OUT     <= '0;
            EXT_DATA_OE_N    <= '1;
        end else begin
            EXT_ADDR         <= mux_addr;
            EXT_WR_N         <= mux_wr_n;
            EXT_DATA_OUT     <= mux_dout;
            // Upper half stays off the pins on a 16-bit bus
            EXT_DATA_OE_N    <= {{16{mux_doe_n | ~WIDE_BUS}},
                                 {16{mux_doe_n}}};
            EXT_CS_N         <= smc_cs_gated;
            if (cs1_sdram_select) begin
                EXT_CS_N[1] <= sdram_owns ? SDR_CS_N : 1'b1;
            end
            EXT_RD_N         <= sdram_owns | SMC_RD_N;
            EXT_WE_N         <= sdram_owns | SMC_WE_N;
            SDRAM_ADDR10_OUT <= sdram_owns & SDR_ADDR[10];
            EXT_RAS_N        <= ~sdram_owns | SDR_RAS_N;
            EXT_CAS_N        <= ~sdram_owns | SDR_CAS_N;
            EXT_SDWE_N       <= ~sdram_owns | SDR_WE_N;
        end
    end

    // Glue logic for NAND and card slots, driven from static strobes
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            NAND_CS_N <= 1'b1;
            NAND_OE_N <= 1'b1;
            NAND_WE_N <= 1'b1;
            CARD_CS_N <= 2'b11;
            CARD_OE_N <= 1'b1;
            CARD_WE_N <= 1'b1;
        end else begin
            NAND_CS_N <= ~cs3_nand_logic_enable | smc_cs_gated[3];
            NAND_OE_N <= ~cs3_nand_logic_enable | smc_cs_gated[3]
                         | SMC_RD_N | sdram_owns;
            NAND_WE_N <= ~cs3_nand_logic_enable | smc_cs_gated[3]
                         | SMC_WE_N | sdram_owns;
            CARD_CS_N[0] <= ~cs4_card_slot1_enable | smc_cs_gated[4];
            CARD_CS_N[1] <= ~cs5_card_slot2_enable | smc_cs_gated[5];
            CARD_OE_N <= ~((cs4_card_slot1_enable & ~smc_cs_gated[4])
                         | (cs5_card_slot2_enable & ~smc_cs_gated[5]))
                         | SMC_RD_N;
            CARD_WE_N <= ~((cs4_card_slot1_enable & ~smc_cs_gated[4])
                         | (cs5_card_slot2_enable & ~smc_cs_gated[5]))
                         | SMC_WE_N;
        end
    end

    // Read data goes to both controllers; wait only to the static side
    assign SMC_DIN    = EXT_DATA_IN;
    assign SDR_DIN    = EXT_DATA_IN;
    assign SMC_WAIT_N = EXT_WAIT_N;

    reset_value_a: assert property (@(posedge CLK_SYS)
        $fell(RST) |-> ext_bus_cs_assign == CS_ASSIGN_RESET)
        else $error("assignment register reset value wrong");
    reg_write_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        wr_access && hit |=>
        ext_bus_cs_assign == ($past(PWDATA) & CS_ASSIGN_MASK))
        else $error("register write not stored");
    cs1_static_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        !cs1_sdram_select |=> EXT_CS_N[1] == $past(smc_cs_gated[1]))
        else $error("select 1 not from static side");
    cs1_sdram_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        cs1_sdram_select && SDRAM_ACCESS && !SDR_CS_N |=> !EXT_CS_N[1])
        else $error("select 1 not from SDRAM side");
    nand_off_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        !cs3_nand_logic_enable |=> NAND_CS_N && NAND_OE_N && NAND_WE_N)
        else $error("NAND glue active while disabled");
    card1_sel_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        cs4_card_slot1_enable && !smc_cs_gated[4] |=> !CARD_CS_N[0])
        else $error("card slot 1 select missing");
    card2_off_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        !cs5_card_slot2_enable |=> CARD_CS_N[1])
        else $error("card slot 2 select while disabled");
    pullup_ctl_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        DATA_PULLUP_EN == !ext_bus_cs_assign[PULLUP_DIS_BIT])
        else $error("pull-up control inverted");
    drive_class_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        wr_access && hit |=> PAD_DRIVE_CLASS == $past(PWDATA[17:16]))
        else $error("drive class not updated");
    addr10_static_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        !sdram_owns |=> !SDRAM_ADDR10_OUT)
        else $error("address 10 driven for static access");
    exclusive_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        sdram_owns |=> EXT_RD_N && EXT_WE_N && EXT_CS_N[0])
        else $error("static strobes active during SDRAM access");

    sdram_access_c: cover property (@(posedge CLK_SYS) disable iff (RST)
        sdram_owns ##1 !EXT_CS_N[1]);
    nand_access_c: cover property (@(posedge CLK_SYS) disable iff (RST)
        !NAND_OE_N);
    card_access_c: cover property (@(posedge CLK_SYS) disable iff (RST)
        !CARD_CS_N[1]);
endmodule

// *** ext_mem_model.sv ***
`timescale 1ns/10ps
module ext_mem_model #(
    parameter logic [31:0] RD_WORD  = 32'h5a3c96e1,
    parameter int          WAIT_CYC = 2
) (
    input  wire logic        CLK_SYS,
    input  wire logic [7:0]  EXT_CS_N,
    input  wire logic        EXT_RD_N,
    input  wire logic [31:0] EXT_DATA_OUT,
    input  wire logic [31:0] EXT_DATA_OE_N,
    input  wire logic        DATA_PULLUP_EN,
    output logic      [31:0] EXT_DATA_IN,
    output logic             EXT_WAIT_N
);
    logic [31:0] idle = 32'h0;
    int          cnt  = 0;
    logic        rd;
    assign rd = (&EXT_CS_N) == 1'b0 && !EXT_RD_N;
    // Released lines toggle, except lines 0 to 15 while pulled up, so a stale value never looks valid
    always @(posedge CLK_SYS) begin
        idle <= ~idle;
        cnt <= rd ? cnt + 1 : 0;
    end
    // Slow device: holds wait low at the start of each read
    assign EXT_WAIT_N = !(rd && cnt < WAIT_CYC);
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (!EXT_DATA_OE_N[i])
                EXT_DATA_IN[i] = EXT_DATA_OUT[i];
            else if (rd)
                EXT_DATA_IN[i] = RD_WORD[i];
            else if (i < 16 && DATA_PULLUP_EN)
                EXT_DATA_IN[i] = 1'b1;
            else
                EXT_DATA_IN[i] = idle[i];
        end
    end
endmodule

// *** testbench.sv ***
`timescale 1ns/10ps
module testbench;
    import ext_bus_pkg::*;
    logic CLK_SYS = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic SMC_RD_N = 1, SMC_WE_N = 1, SMC_DOE_N = 1, SDR_DOE_N = 1;
    logic SDRAM_ACCESS = 0, SDR_CS_N = 1, SDR_RAS_N = 1, SDR_CAS_N = 1;
    logic SDR_WE_N = 1, WIDE_BUS = 1;
    logic [11:0] PADDR = 0;
    logic [31:0] PWDATA = 0, SMC_DOUT = 0, SDR_DOUT = 0;
    logic [7:0] SMC_CS_N = 8'hff, EXT_CS_N;
    logic [3:0] SMC_WR_N = 4'hf, SDR_DQM_N = 4'hf, EXT_WR_N;
    logic [ADDR_W-1:0] SMC_ADDR = 0, EXT_ADDR;
    logic [12:0] SDR_ADDR = 0;
    logic [31:0] PRDATA, SMC_DIN, SDR_DIN, EXT_DATA_OUT, EXT_DATA_OE_N;
    logic [31:0] EXT_DATA_IN, rd;
    logic PREADY, PSLVERR, SMC_WAIT_N, EXT_RD_N, EXT_WE_N, EXT_WAIT_N;
    logic SDRAM_ADDR10_OUT, EXT_RAS_N, EXT_CAS_N, EXT_SDWE_N, NAND_CS_N;
    logic NAND_OE_N, NAND_WE_N, CARD_OE_N, CARD_WE_N, DATA_PULLUP_EN;
    logic [1:0] CARD_CS_N, PAD_DRIVE_CLASS;
    int mismatches = 0, samples_checked = 0;

    ext_bus_cs_mux u_ext_bus_cs_mux (.*);
    ext_mem_model u_ext_mem_model (.*);

    always #50 CLK_SYS = ~CLK_SYS;

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge CLK_SYS);
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1;
        do @(posedge CLK_SYS); while (PREADY !== 1'b1);
        rd = PRDATA;
        PSEL <= 0;
        PENABLE <= 0;
    endtask
    task wr(input logic [31:0] d);
        apb(1, CS_ASSIGN_ADDR, d);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        #200000;
        mismatches++;
        finish_test;
    end

    initial begin
        tick(3);
        RST <= 0;
        apb(0, CS_ASSIGN_ADDR, 0);
        check(rd, CS_ASSIGN_RESET);
        check(PAD_DRIVE_CLASS, 1);
        check(SMC_DIN[15:0], 16'hffff);
        check({PREADY, PSLVERR}, 2'b10);
        wr('1);
        apb(0, CS_ASSIGN_ADDR, 0);
        check(rd, CS_ASSIGN_MASK);
        apb(1, 12'h120, 0);
        apb(0, 12'h118, 0);
        check(rd, 0);
        apb(0, CS_ASSIGN_ADDR, 0);
        check(rd, CS_ASSIGN_MASK);
        for (int i = 0; i < 4; i++) begin
            wr((32'(i) << DRIVE_LSB) | (32'(i & 1) << PULLUP_DIS_BIT));
            tick(1);
            check(PAD_DRIVE_CLASS, 32'(i));
            check(DATA_PULLUP_EN, 32'(~i & 1));
        end
        $display("register test done");
        wr(0);
        SMC_CS_N <= 8'hfd;
        tick(2);
        check(EXT_CS_N, 8'hfd);
        wr(32'h1 << CS1_SDRAM_BIT);
        tick(2);
        check(EXT_CS_N, 8'hff);
        SDRAM_ACCESS <= 1;
        SDR_CS_N <= 0;
        SDR_RAS_N <= 0;
        SDR_ADDR <= 13'h1555;
        SMC_RD_N <= 0;
        SMC_CS_N <= 8'hfe;
        SMC_ADDR <= 26'h2abcdef;
        tick(2);
        check(EXT_CS_N, 8'hfd);
        check(EXT_RD_N, 1);
        check(EXT_RAS_N, 0);
        check(SDRAM_ADDR10_OUT, 1);
        check(EXT_ADDR, {11'h0, 2'b10, 1'b0, 10'h155, 2'b0});
        SDRAM_ACCESS <= 0;
        tick(2);
        check(EXT_ADDR, 26'h2abcdef);
        check(SDRAM_ADDR10_OUT, 0);
        check(EXT_RAS_N, 1);
        check(EXT_CS_N, 8'hfe);
        check(SMC_WAIT_N, 0);
        check(SMC_DIN, 32'h5a3c96e1);
        check(SDR_DIN, 32'h5a3c96e1);
        tick(3);
        check(SMC_WAIT_N, 1);
        SMC_RD_N <= 1;
        $display("routing test done");
        for (int i = 0; i < 3; i++) begin
            wr(32'h1 << (CS3_NAND_BIT + i));
            SMC_CS_N <= ~(8'h1 << (CS3_NAND_BIT + i));
            SMC_WE_N <= 0;
            tick(2);
            check({CARD_CS_N, NAND_CS_N}, {29'h0, ~(3'b1 << i)});
            check({CARD_WE_N, NAND_WE_N}, (i == 0) ? 2 : 1);
            check(EXT_WE_N, 0);
            check(EXT_CS_N, {24'h0, ~(8'h1 << (CS3_NAND_BIT + i))});
            wr(0);
            tick(2);
            check({CARD_CS_N, NAND_CS_N}, 7);
            check({CARD_WE_N, NAND_WE_N}, 3);
        end
        SMC_CS_N <= 8'hff;
        SMC_WE_N <= 1;
        $display("glue test done");
        WIDE_BUS <= 0;
        SMC_DOE_N <= 0;
        SMC_DOUT <= 32'h1234abcd;
        tick(2);
        check(EXT_DATA_OE_N, 32'hffff0000);
        check(EXT_DATA_OUT[15:0], 16'habcd);
        WIDE_BUS <= 1;
        tick(2);
        check(EXT_DATA_OE_N, 0);
        SMC_DOE_N <= 1;
        $display("data bus test done");
        finish_test;
    end
endmodule
